// >>> design/rtcc_divider.sv
`timescale 1ns/1ps
module rtcc_divider #(
    parameter int unsigned DIV_COUNT = rtcc_pkg::CRYSTAL_HZ
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic osc_tick,
    rtcc_tick_if.src tk
);
    localparam int unsigned CW = $clog2(DIV_COUNT) + 1;
    localparam int SQ_BIT = $clog2(rtcc_pkg::CRYSTAL_HZ / rtcc_pkg::SQUARE_HZ) - 1;

    generate
        if (DIV_COUNT < 128 || DIV_COUNT % 64 != 0) begin : g_bad
            $error("divider count must be a multiple of 64, at least 128");
        end
    endgenerate

    logic [CW-1:0] cnt;
    logic [6:0] acc;
    logic sec_tick;
    logic sq;

    // one correction pulse per crystal tick while the credit lasts
    wire corr = osc_tick && (acc >= 7'(rtcc_pkg::CORR_DEN));
    wire sign = tk.cal_code[rtcc_pkg::BIT_CAL_SIGN];
    wire [1:0] step = corr ? (sign ? 2'h2 : 2'h0) : 2'h1;
    wire [CW:0] sum = {1'b0, cnt} + (CW+1)'(step);
    wire wrap = sum >= (CW+1)'(DIV_COUNT);
    wire [CW-1:0] cnt_wrapped = CW'(sum - (CW+1)'(DIV_COUNT));
    wire [CW-1:0] next_cnt = !osc_tick ? cnt : (wrap ? cnt_wrapped : sum[CW-1:0]);
    wire [6:0] add = sec_tick ? {2'h0, tk.cal_code[4:0]} : 7'h00;
    wire [6:0] sub = corr ? 7'(rtcc_pkg::CORR_DEN) : 7'h00;
    wire [6:0] next_acc = acc + add - sub;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt <= '0;
            acc <= 7'h00;
            sec_tick <= 1'b0;
            sq <= 1'b0;
        end else begin
            cnt <= next_cnt;
            acc <= next_acc;
            sec_tick <= osc_tick && wrap;
            sq <= cnt[SQ_BIT];
        end
    end

    assign tk.sec_tick = sec_tick;
    assign tk.sq512 = sq;

    property p_sec_tick;
        @(posedge clk_sys) disable iff (srst)
        (osc_tick && !corr && cnt == CW'(DIV_COUNT - 1)) |=> sec_tick;
    endproperty
    a_sec_tick: assert property (p_sec_tick) else $error("second tick missed");

    property p_add_pulse;
        @(posedge clk_sys) disable iff (srst)
        (corr && sign && !wrap) |=> cnt == CW'($past(cnt) + 2);
    endproperty
    a_add_pulse: assert property (p_add_pulse) else $error("pulse not added");
endmodule

// >>> design/rtcc_pkg.sv
package rtcc_pkg;
    localparam int unsigned CRYSTAL_HZ = 32768;
    localparam int unsigned SQUARE_HZ = 512;
    localparam int unsigned CORR_DEN = 7;
    localparam int unsigned NUM_FIELDS = 7;
    localparam int unsigned CAL_W = 6;

    localparam logic [4:0] ADDR_CLOCK_CTL = 5'h00;
    localparam logic [4:0] ADDR_CAL_CTL = 5'h01;
    localparam logic [4:0] ADDR_SECONDS = 5'h02;
    localparam logic [4:0] ADDR_YEARS = 5'h08;
    localparam logic [4:0] ADDR_COMPANION = 5'h0B;

    localparam int BIT_SNAPSHOT = 0;
    localparam int BIT_LOCK = 1;
    localparam int BIT_CAL_MODE = 2;
    localparam int BIT_CAL_SIGN = 5;
    localparam int BIT_TRICKLE = 2;

    localparam int F_SEC = 0;
    localparam int F_MIN = 1;
    localparam int F_HOUR = 2;
    localparam int F_DAY = 3;
    localparam int F_DATE = 4;
    localparam int F_MONTH = 5;
    localparam int F_YEAR = 6;

    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DAY_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] DAYS_FEB = 8'h28;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
    localparam logic [7:0] DAYS_SHORT = 8'h30;
    localparam logic [7:0] DAYS_LONG = 8'h31;

    typedef logic [NUM_FIELDS-1:0][7:0] rtcc_time_t;

    // year, month, date, day, hours, minutes, seconds
    localparam rtcc_time_t TIME_RESET = 56'h00_01_01_01_00_00_00;
    localparam rtcc_time_t FIELD_MASK = 56'hFF_1F_3F_07_3F_7F_7F;
    localparam logic [CAL_W-1:0] CAL_NONE = 6'h00;
endpackage

// >>> design/rtcc_supply.sv
`timescale 1ns/1ps
module rtcc_supply (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic vdd_low,
    input wire logic backup_supply_pin_full,
    input wire logic trickle_en,
    output logic backup_select,
    output logic charge_on
);
    // charging needs the main supply; it stops once backup_supply_pin_full is set
    wire next_charge = trickle_en && !backup_supply_pin_full && !vdd_low;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            backup_select <= 1'b0;
            charge_on <= 1'b0;
        end else begin
            backup_select <= vdd_low;
            charge_on <= next_charge;
        end
    end

    property p_switch;
        @(posedge clk_sys) disable iff (srst)
        vdd_low |=> backup_select && !charge_on;
    endproperty
    a_switch: assert property (p_switch) else $error("no backup switchover");

    property p_charge;
        @(posedge clk_sys) disable iff (srst)
        (trickle_en && !backup_supply_pin_full && !vdd_low) |=> charge_on;
    endproperty
    a_charge: assert property (p_charge) else $error("trickle charge not on");
endmodule

// >>> design/rtcc_tick_if.sv
`timescale 1ns/1ps
interface rtcc_tick_if;
    logic sec_tick;
    logic sq512;
    logic [rtcc_pkg::CAL_W-1:0] cal_code;
    modport src (output sec_tick, output sq512, input cal_code);
    modport dst (input sec_tick, input sq512, output cal_code);
endinterface

// >>> design/rtcc_timekeeper.sv
`timescale 1ns/1ps
module rtcc_timekeeper #(
    parameter int unsigned DIV_COUNT = rtcc_pkg::CRYSTAL_HZ
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic osc_tick,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic pfo_in,
    input wire logic vdd_low,
    input wire logic backup_supply_pin_full,
    input wire logic [5:0] nv_cal_code,
    output logic nv_cal_write,
    output logic [5:0] nv_cal_data,
    output logic shared_cal_powerfail_pin,
    output logic backup_supply_select,
    output logic backup_supply_pin_charge
);
    rtcc_tick_if tk ();

    logic snap;
    logic lock;
    logic cal_mode;
    logic trickle_charge_enable;
    logic [5:0] cal_code;
    logic pend;
    logic pin;
    rtcc_pkg::rtcc_time_t hold;
    rtcc_pkg::rtcc_time_t core;
    rtcc_pkg::rtcc_time_t core_adv;
    rtcc_pkg::rtcc_time_t next_hold;
    rtcc_pkg::rtcc_time_t next_core;
    logic [7:0] next_rdata;

    function automatic logic [8:0] bcd_step(
        input logic [7:0] v,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        // the >= also pulls an out-of-range code back into range
        if (v >= hi) begin
            return {1'b1, lo};
        end
        if (v[3:0] >= 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return {1'b0, v + 8'h01};
    endfunction

    function automatic logic leap_year(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_days(
        input logic [7:0] m,
        input logic [7:0] y
    );
        if (m == rtcc_pkg::MON_FEB) begin
            return leap_year(y) ? rtcc_pkg::DAYS_FEB_LEAP : rtcc_pkg::DAYS_FEB;
        end
        case (m)
            8'h04, 8'h06, 8'h09, 8'h11: return rtcc_pkg::DAYS_SHORT;
            default: return rtcc_pkg::DAYS_LONG;
        endcase
    endfunction

    function automatic rtcc_pkg::rtcc_time_t time_inc(input rtcc_pkg::rtcc_time_t t);
        rtcc_pkg::rtcc_time_t r;
        logic [8:0] s;
        logic [7:0] mdays;
        r = t;
        mdays = month_days(t[rtcc_pkg::F_MONTH], t[rtcc_pkg::F_YEAR]);
        s = bcd_step(t[rtcc_pkg::F_SEC], rtcc_pkg::BCD_ZERO, rtcc_pkg::SEC_MAX);
        r[rtcc_pkg::F_SEC] = s[7:0];
        if (s[8]) begin
            s = bcd_step(t[rtcc_pkg::F_MIN], rtcc_pkg::BCD_ZERO, rtcc_pkg::SEC_MAX);
            r[rtcc_pkg::F_MIN] = s[7:0];
            if (s[8]) begin
                s = bcd_step(t[rtcc_pkg::F_HOUR], rtcc_pkg::BCD_ZERO, rtcc_pkg::HOUR_MAX);
                r[rtcc_pkg::F_HOUR] = s[7:0];
                if (s[8]) begin
                    s = bcd_step(t[rtcc_pkg::F_DAY], rtcc_pkg::BCD_ONE, rtcc_pkg::DAY_MAX);
                    r[rtcc_pkg::F_DAY] = s[7:0];
                    s = bcd_step(t[rtcc_pkg::F_DATE], rtcc_pkg::BCD_ONE, mdays);
                    r[rtcc_pkg::F_DATE] = s[7:0];
                    if (s[8]) begin
                        s = bcd_step(t[rtcc_pkg::F_MONTH], rtcc_pkg::BCD_ONE,
                            rtcc_pkg::MONTH_MAX);
                        r[rtcc_pkg::F_MONTH] = s[7:0];
                        if (s[8]) begin
                            s = bcd_step(t[rtcc_pkg::F_YEAR], rtcc_pkg::BCD_ZERO,
                                rtcc_pkg::YEAR_MAX);
                            r[rtcc_pkg::F_YEAR] = s[7:0];
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    rtcc_divider #(
        .DIV_COUNT(DIV_COUNT)
    ) u_divider (
        .clk_sys(clk_sys),
        .srst(srst),
        .osc_tick(osc_tick),
        .tk(tk.src)
    );

    rtcc_supply u_supply (
        .clk_sys(clk_sys),
        .srst(srst),
        .vdd_low(vdd_low),
        .backup_supply_pin_full(backup_supply_pin_full),
        .trickle_en(trickle_charge_enable),
        .backup_select(backup_supply_select),
        .charge_on(backup_supply_pin_charge)
    );

    assign tk.cal_code = cal_code;

    // register decode
    wire wr_ctl = reg_wr && (reg_addr == rtcc_pkg::ADDR_CLOCK_CTL);
    wire wr_cal = reg_wr && (reg_addr == rtcc_pkg::ADDR_CAL_CTL);
    wire wr_comp = reg_wr && (reg_addr == rtcc_pkg::ADDR_COMPANION);
    wire in_time = (reg_addr >= rtcc_pkg::ADDR_SECONDS) && (reg_addr <= rtcc_pkg::ADDR_YEARS);
    wire wr_time = reg_wr && in_time;
    wire [2:0] time_idx = 3'(reg_addr - rtcc_pkg::ADDR_SECONDS);

    wire w_snap = reg_wdata[rtcc_pkg::BIT_SNAPSHOT];
    wire w_lock = reg_wdata[rtcc_pkg::BIT_LOCK];
    wire w_cal_mode = reg_wdata[rtcc_pkg::BIT_CAL_MODE];
    wire snap_rise = wr_ctl && w_snap && !snap;
    wire lock_fall = wr_ctl && !w_lock && lock;

    wire next_snap = wr_ctl ? w_snap : snap;
    wire next_lock = wr_ctl ? w_lock : lock;
    wire next_cal_mode = wr_ctl ? w_cal_mode : cal_mode;
    wire next_trickle = wr_comp ? reg_wdata[rtcc_pkg::BIT_TRICKLE] : trickle_charge_enable;
    // the code is only taken while calibration mode is already on
    wire cal_take = wr_cal && cal_mode;
    wire [5:0] next_cal = cal_take ? reg_wdata[rtcc_pkg::CAL_W-1:0] : cal_code;

    // a tick during the write lock is dropped: the new time starts fresh
    wire next_pend = tk.sec_tick || (pend && lock && !lock_fall);
    wire next_pin = cal_mode ? tk.sq512 : pfo_in;

    // a pending step is folded in here, so a snapshot never sees a stale core
    assign core_adv = pend ? time_inc(core) : core;

    always_comb begin
        next_core = core;
        if (lock_fall) begin
            next_core = hold;
        end else if (!lock) begin
            next_core = core_adv;
        end
    end

    always_comb begin
        next_hold = hold;
        if (wr_time) begin
            next_hold[time_idx] = reg_wdata & rtcc_pkg::FIELD_MASK[time_idx];
        end else if (snap_rise) begin
            next_hold = core_adv;
        end else if (!snap && !lock) begin
            next_hold = core_adv;
        end
    end

    always_comb begin
        next_rdata = rtcc_pkg::BCD_ZERO;
        if (in_time) begin
            next_rdata = hold[time_idx];
        end
        case (reg_addr)
            rtcc_pkg::ADDR_CLOCK_CTL: begin
                next_rdata[rtcc_pkg::BIT_SNAPSHOT] = snap;
                next_rdata[rtcc_pkg::BIT_LOCK] = lock;
                next_rdata[rtcc_pkg::BIT_CAL_MODE] = cal_mode;
            end
            rtcc_pkg::ADDR_CAL_CTL: begin
                next_rdata[rtcc_pkg::CAL_W-1:0] = cal_code;
            end
            rtcc_pkg::ADDR_COMPANION: begin
                next_rdata[rtcc_pkg::BIT_TRICKLE] = trickle_charge_enable;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            snap <= 1'b0;
            lock <= 1'b0;
            cal_mode <= 1'b0;
            trickle_charge_enable <= 1'b0;
            pend <= 1'b0;
        end else begin
            snap <= next_snap;
            lock <= next_lock;
            cal_mode <= next_cal_mode;
            trickle_charge_enable <= next_trickle;
            pend <= next_pend;
        end
    end

    // reset reloads the code from the nonvolatile cell, not a constant
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cal_code <= nv_cal_code;
            nv_cal_write <= 1'b0;
            nv_cal_data <= rtcc_pkg::CAL_NONE;
        end else begin
            cal_code <= next_cal;
            nv_cal_write <= cal_take;
            nv_cal_data <= reg_wdata[rtcc_pkg::CAL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            core <= rtcc_pkg::TIME_RESET;
            hold <= rtcc_pkg::TIME_RESET;
        end else begin
            core <= next_core;
            hold <= next_hold;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin <= 1'b1;
            reg_rdata <= rtcc_pkg::BCD_ZERO;
        end else begin
            pin <= next_pin;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    assign shared_cal_powerfail_pin = pin;

    property p_snap_copy;
        @(posedge clk_sys) disable iff (srst)
        (snap_rise && !lock) |=> (hold == core);
    endproperty
    a_snap_copy: assert property (p_snap_copy) else $error("snapshot not copied");

    property p_pend_first;
        @(posedge clk_sys) disable iff (srst)
        (snap_rise && pend && !lock) |=> (hold == time_inc($past(core)));
    endproperty
    a_pend_first: assert property (p_pend_first) else $error("pending step lost");

    property p_frozen;
        @(posedge clk_sys) disable iff (srst)
        (snap && !wr_time && !wr_ctl) ##1 (snap && !wr_time) |=> $stable(hold);
    endproperty
    a_frozen: assert property (p_frozen) else $error("holding changed in snapshot");

    property p_lock_hold;
        @(posedge clk_sys) disable iff (srst)
        (lock && !wr_time && !snap_rise) |=> $stable(hold);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("holding changed in lock");

    property p_lock_load;
        @(posedge clk_sys) disable iff (srst)
        lock_fall |=> (core == $past(hold)) && (pend == $past(tk.sec_tick));
    endproperty
    a_lock_load: assert property (p_lock_load) else $error("core not loaded");

    property p_core_run;
        @(posedge clk_sys) disable iff (srst)
        (pend && !lock) |=> (core == time_inc($past(core)));
    endproperty
    a_core_run: assert property (p_core_run) else $error("core missed a step");

    property p_core_lock;
        @(posedge clk_sys) disable iff (srst)
        (lock && !lock_fall) |=> $stable(core);
    endproperty
    a_core_lock: assert property (p_core_lock) else $error("core moved in lock");

    property p_cal_ignore;
        @(posedge clk_sys) disable iff (srst)
        (wr_cal && !cal_mode) |=> $stable(cal_code) && !nv_cal_write;
    endproperty
    a_cal_ignore: assert property (p_cal_ignore) else $error("code written outside");

    property p_pin_cal;
        @(posedge clk_sys) disable iff (srst)
        cal_mode |=> (shared_cal_powerfail_pin == $past(tk.sq512));
    endproperty
    a_pin_cal: assert property (p_pin_cal) else $error("pin not square wave");

    property p_pin_pf;
        @(posedge clk_sys) disable iff (srst)
        !cal_mode |=> (shared_cal_powerfail_pin == $past(pfo_in));
    endproperty
    a_pin_pf: assert property (p_pin_pf) else $error("pin not powerfail");
endmodule

// >>> verif/rtcc_timekeeper_tb_top.sv
`timescale 1ns/1ps
module rtcc_timekeeper_tb_top;
    localparam int DIV = 128;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic osc_tick = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pfo_in = 1'b1;
    logic vdd_low = 1'b0;
    logic backup_supply_pin_full = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic nv_cal_write;
    logic pin;
    logic bsel;
    logic chg;
    logic [5:0] nv_cal_data;
    // nonvolatile cell model: keeps the last stored code and feeds it back at reset
    logic [5:0] nvw_last = 6'h21;
    int wk;
    int fails = 0;
    int check_count = 0;
    int osc_n = 0;
    int nvw_n = 0;
    int cyc = 0;
    int mn;
    int mx;
    rtcc_pkg::rtcc_time_t tv;
    // two late-February cases: plain year and leap year
    rtcc_pkg::rtcc_time_t set_t [2] = '{56'h03_02_28_07_23_59_59, 56'h04_02_28_07_23_59_59};
    rtcc_pkg::rtcc_time_t exp_t [2] = '{56'h03_03_01_01_00_00_00, 56'h04_02_29_01_00_00_00};

    rtcc_timekeeper #(.DIV_COUNT(DIV)) u_dut (
        .clk_sys(clk_sys),
        .srst(srst),
        .osc_tick(osc_tick),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .pfo_in(pfo_in),
        .vdd_low(vdd_low),
        .backup_supply_pin_full(backup_supply_pin_full),
        .nv_cal_code(nvw_last),
        .nv_cal_write(nv_cal_write),
        .nv_cal_data(nv_cal_data),
        .shared_cal_powerfail_pin(pin),
        .backup_supply_select(bsel),
        .backup_supply_pin_charge(chg)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // crystal ticks every other cycle; osc_n lets tests keep clear of second wraps
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        osc_tick <= !srst && cyc[0];
        if (osc_tick) begin
            osc_n <= osc_n + 1;
        end
        if (nv_cal_write) begin
            nvw_n <= nvw_n + 1;
            nvw_last <= nv_cal_data;
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task rdc(input string what, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] b;
        rd(a, b);
        chk(what, e, b);
    endtask

    task chk_time(input rtcc_pkg::rtcc_time_t e);
        logic [7:0] b;
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h01);
        for (int i = 0; i < 7; i++) begin
            rd(rtcc_pkg::ADDR_SECONDS + 5'(i), b);
            chk($sformatf("time field %0d", i), e[i], b);
        end
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
    endtask

    // wait until the divider sits well away from its wrap point
    task align;
        int k;
        repeat (4) @(posedge clk_sys);
        for (k = 0; k < 400 && osc_n % DIV != 40; k++) begin
            @(posedge clk_sys);
        end
        if (k == 400) begin
            fails++;
            stop_test;
        end
    endtask

    // crystal ticks between edges of the shared pin, smallest and largest
    task measure(output int lo, output int hi);
        int n;
        int k;
        logic last;
        lo = 999;
        hi = 0;
        @(negedge clk_sys);
        last = pin;
        for (k = 0; k < 300 && pin === last; k++) begin
            @(negedge clk_sys);
        end
        if (k == 300) begin
            fails++;
            stop_test;
        end
        last = pin;
        n = 0;
        repeat (1000) begin
            @(negedge clk_sys);
            if (osc_tick) begin
                n++;
            end
            if (pin !== last) begin
                last = pin;
                lo = n < lo ? n : lo;
                hi = n > hi ? n : hi;
                n = 0;
            end
        end
    endtask

    initial begin
        #400000;
        fails++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        rdc("clock ctl", rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        rdc("cal ctl", rtcc_pkg::ADDR_CAL_CTL, 8'h21);
        rdc("companion", rtcc_pkg::ADDR_COMPANION, 8'h00);
        wr(5'h1F, 8'hFF);
        rdc("unmapped", 5'h1F, 8'h00);
        chk("pin", 8'h01, {7'h00, pin});
        chk_time(rtcc_pkg::TIME_RESET);
        // valid codes only are loaded into the time registers
        for (int c = 0; c < 2; c++) begin
            align;
            wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h02);
            for (int i = 0; i < 7; i++) begin
                wr(rtcc_pkg::ADDR_SECONDS + 5'(i), set_t[c][i]);
            end
            wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
            chk_time(set_t[c]);
            align;
            chk_time(exp_t[c]);
        end
        align;
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h02);
        wr(rtcc_pkg::ADDR_SECONDS, 8'h10);
        align;
        align;
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h01);
        rdc("sec after lock", rtcc_pkg::ADDR_SECONDS, 8'h10);
        align;
        align;
        align;
        rdc("sec frozen", rtcc_pkg::ADDR_SECONDS, 8'h10);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h01);
        rdc("sec snapshot", rtcc_pkg::ADDR_SECONDS, 8'h13);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        // snapshot in the cycle a step is pending must show the new second
        @(posedge clk_sys);
        for (wk = 0; wk < 400 && u_dut.tk.sec_tick !== 1'b1; wk++) begin
            @(posedge clk_sys);
        end
        if (wk == 400) begin
            fails++;
            stop_test;
        end
        reg_wr <= 1'b1;
        reg_addr <= rtcc_pkg::ADDR_CLOCK_CTL;
        reg_wdata <= 8'h01;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        rdc("sec pending", rtcc_pkg::ADDR_SECONDS, 8'h14);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        // code write outside calibration mode must not land
        wr(rtcc_pkg::ADDR_CAL_CTL, 8'h3F);
        repeat (3) @(posedge clk_sys);
        chk("nv writes", 8'h00, 8'(nvw_n));
        rdc("cal ctl", rtcc_pkg::ADDR_CAL_CTL, 8'h21);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h04);
        pfo_in <= 1'b0;
        rdc("clock ctl", rtcc_pkg::ADDR_CLOCK_CTL, 8'h04);
        wr(rtcc_pkg::ADDR_CAL_CTL, 8'h3F);
        repeat (3) @(posedge clk_sys);
        chk("nv writes", 8'h01, 8'(nvw_n));
        chk("nv data", 8'h3F, {2'b00, nvw_last});
        rdc("cal ctl", rtcc_pkg::ADDR_CAL_CTL, 8'h3F);
        measure(mn, mx);
        chk("add min", 8'h01, {7'h00, mn < 32});
        chk("add max", 8'h01, {7'h00, mx == 32});
        wr(rtcc_pkg::ADDR_CAL_CTL, 8'h1F);
        measure(mn, mx);
        chk("drop min", 8'h01, {7'h00, mn == 32});
        chk("drop max", 8'h01, {7'h00, mx > 32});
        wr(rtcc_pkg::ADDR_CAL_CTL, 8'h00);
        // let any credit left from the old code drain before measuring
        repeat (12) @(posedge clk_sys);
        measure(mn, mx);
        chk("zero min", 8'h20, 8'(mn));
        chk("zero max", 8'h20, 8'(mx));
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("pin fail", 8'h00, {7'h00, pin});
        pfo_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("pin ok", 8'h01, {7'h00, pin});
        for (int m = 0; m < 8; m++) begin
            wr(rtcc_pkg::ADDR_COMPANION, m[2] ? 8'h04 : 8'h00);
            vdd_low <= m[1];
            backup_supply_pin_full <= m[0];
            rdc("companion", rtcc_pkg::ADDR_COMPANION, m[2] ? 8'h04 : 8'h00);
            chk("backup select", {7'h00, m[1]}, {7'h00, bsel});
            chk("charge", {7'h00, m[2] & !m[1] & !m[0]}, {7'h00, chg});
        end
        // leave the charger off, as a battery-backed system would
        wr(rtcc_pkg::ADDR_COMPANION, 8'h00);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h04);
        wr(rtcc_pkg::ADDR_CAL_CTL, 8'h2A);
        wr(rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        // a second reset must bring the stored code back from the cell
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rdc("cal after reset", rtcc_pkg::ADDR_CAL_CTL, 8'h2A);
        rdc("ctl after reset", rtcc_pkg::ADDR_CLOCK_CTL, 8'h00);
        stop_test;
    end
endmodule
